// ===== common/itsp_pkg.sv
// Constants, field layouts and carrier types of the ISDN TDM serial port
package itsp_pkg;

  // Register offsets (byte addresses)
  localparam logic [3:0]  ADDR_CTRL = 4'h0;
  localparam logic [3:0]  ADDR_MASK = 4'h4;
  localparam logic [3:0]  ADDR_STAT = 4'h8;

  // Control register layout, LSB first: mode, mux, D, B1, B2 routes, enable
  typedef struct packed {
    logic       enable;
    logic [1:0] b2_route;
    logic [1:0] b1_route;
    logic [1:0] d_route;
    logic       gci_mux;
    logic       general_circuit_iface;
  } itsp_ctrl_s;
  localparam int          CTRL_W    = 9;
  localparam logic [8:0]  CTRL_RST  = 9'h000;
  localparam logic [15:0] MASK_RST  = 16'hFFFF;

  // Interchip link frame: B1, D, A, B2, D, M
  localparam logic [7:0]  IDL_B1_LO = 8'h00;
  localparam logic [7:0]  IDL_D0    = 8'h08;
  localparam logic [7:0]  IDL_A     = 8'h09;
  localparam logic [7:0]  IDL_B2_LO = 8'h0A;
  localparam logic [7:0]  IDL_D1    = 8'h12;
  localparam logic [7:0]  IDL_M     = 8'h13;
  localparam logic [7:0]  IDL_LAST  = 8'h13;

  // General circuit frame: 32 bits per channel, up to 8 channels
  localparam logic [4:0]  GCI_B1_LO = 5'h00;
  localparam logic [4:0]  GCI_B2_LO = 5'h08;
  localparam logic [4:0]  GCI_M_LO  = 5'h10;
  localparam logic [4:0]  GCI_D_LO  = 5'h18;
  localparam logic [4:0]  GCI_CI_LO = 5'h1A;
  localparam logic [7:0]  GCI_LAST  = 8'h1F;
  localparam logic [7:0]  GCI_MUX_LAST = 8'hFF;
  localparam logic [2:0]  GCI_FREE_CH  = 3'h2;
  localparam logic [4:0]  GCI_FREE_POS = 5'h1D;

  // Controller indices
  localparam logic [2:0]  DEST_MANAGEMENT_CONTROLLER_ONE = 3'h3;
  localparam logic [2:0]  DEST_MANAGEMENT_CONTROLLER_TWO = 3'h4;
  localparam logic [2:0]  DEST_NONE = 3'h7;
  localparam logic [1:0]  ROUTE_OFF = 2'h3;

  typedef enum logic [2:0] {
    CH_NONE = 3'b000,
    CH_B1   = 3'b001,
    CH_B2   = 3'b010,
    CH_D    = 3'b011,
    CH_M    = 3'b100,
    CH_A    = 3'b101,
    CH_CI   = 3'b110
  } itsp_chan_e;

  typedef struct packed {
    itsp_chan_e chan;
    logic [2:0] idx;
  } itsp_slot_s;

  typedef enum logic [1:0] {
    DS_IDLE = 2'b00,
    DS_WAIT = 2'b01,
    DS_SEND = 2'b10
  } itsp_dstate_e;

endpackage : itsp_pkg

// ===== design/itsp_port.sv
// ISDN TDM serial port, slave side of interchip link and GENERAL_CIRCUIT_IFACE buses
// Notes on behaviour
// - Link mode: 20-bit duplex frame per 125 us
// - Port is bus slave, clocked externally
// - Only the 20-bit link variant exists
// - Link mode: drive only supported bits, else float
// - Link mode: receive only inside the 20 frame bits
// - Link mode: frame is 20 clocks after sync pulse
// - Carry B1, B2, D, M and A channels
// - Route D, B1, B2 to any of serial controllers 0 to 2
// - Link mode: request D channel when data pending
// - Sample grant at sync, then send D
// - Lost grant aborts; retry within two buffers
// - Per-bit bearer mask gates receive and transmit
// - Bearer strobes mark unmasked B1, B2 bits
// - GENERAL_CIRCUIT_IFACE: 8 kHz frame, 256 kbps stream
// - GENERAL_CIRCUIT_IFACE multiplexed frame, eight channels, 2048 kbps
// - GENERAL_CIRCUIT_IFACE: one data bit per two clocks
// - Channel 0, channel 2 C/I access control
// - GENERAL_CIRCUIT_IFACE also honours dchan_grant input
// - GENERAL_CIRCUIT_IFACE transmit open drain, low for zeros
// - GENERAL_CIRCUIT_IFACE outputs data-rate clock
// - GENERAL_CIRCUIT_IFACE checks channel 2 C/I free bit
`timescale 1ns/1ps

module itsp_port (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        line_clock_in,
  input  wire logic        frame_sync_in,
  input  wire logic        line_rx_data,
  input  wire logic        dchan_grant,
  output logic             line_tx_data,
  output logic             line_tx_data_oe_n,
  output logic             dchan_request,
  output logic             bearer_strobe_one,
  output logic             bearer_strobe_two,
  output logic             data_rate_clock_out,
  input  wire logic [4:0]  ctl_tx_bit,
  output logic      [4:0]  ctl_tx_take,
  output logic             ctl_rx_bit,
  output logic      [4:0]  ctl_rx_valid,
  input  wire logic        dchan_pending,
  input  wire logic        dchan_early,
  output logic             dchan_abort,
  output logic             dchan_fail,
  output logic             dchan_sending
);

  // Fixed slot map of both frame formats
  function automatic itsp_pkg::itsp_slot_s slot_of(
    input logic       general_circuit_iface,
    input logic [7:0] pos
  );
    itsp_pkg::itsp_slot_s s;
    s.chan = itsp_pkg::CH_NONE;
    s.idx  = 3'h0;
    if (!general_circuit_iface) begin
      if (pos < itsp_pkg::IDL_D0) begin
        s.chan = itsp_pkg::CH_B1;
        s.idx  = pos[2:0];
      end else if (pos == itsp_pkg::IDL_D0 || pos == itsp_pkg::IDL_D1) begin
        s.chan = itsp_pkg::CH_D;
      end else if (pos == itsp_pkg::IDL_A) begin
        s.chan = itsp_pkg::CH_A;
      end else if (pos == itsp_pkg::IDL_M) begin
        s.chan = itsp_pkg::CH_M;
      end else if (pos >= itsp_pkg::IDL_B2_LO) begin
        s.chan = itsp_pkg::CH_B2;
        s.idx  = 3'(pos - itsp_pkg::IDL_B2_LO);
      end
    end else if (pos[7:5] == 3'h0) begin
      s.idx = pos[2:0];
      if (pos[4:0] < itsp_pkg::GCI_B2_LO) begin
        s.chan = itsp_pkg::CH_B1;
      end else if (pos[4:0] < itsp_pkg::GCI_M_LO) begin
        s.chan = itsp_pkg::CH_B2;
      end else if (pos[4:0] < itsp_pkg::GCI_D_LO) begin
        s.chan = itsp_pkg::CH_M;
      end else if (pos[4:0] < itsp_pkg::GCI_CI_LO) begin
        s.chan = itsp_pkg::CH_D;
      end else begin
        s.chan = itsp_pkg::CH_CI;
      end
    end
    return s;
  endfunction : slot_of

  // Controller that owns a channel, DEST_NONE if unrouted
  function automatic logic [2:0] dest_of(
    input itsp_pkg::itsp_ctrl_s c,
    input itsp_pkg::itsp_chan_e ch
  );
    logic [1:0] r;
    r = itsp_pkg::ROUTE_OFF;
    unique case (ch)
      itsp_pkg::CH_B1: r = c.b1_route;
      itsp_pkg::CH_B2: r = c.b2_route;
      itsp_pkg::CH_D:  r = c.d_route;
      itsp_pkg::CH_M:  return itsp_pkg::DEST_MANAGEMENT_CONTROLLER_ONE;
      itsp_pkg::CH_A,
      itsp_pkg::CH_CI: return itsp_pkg::DEST_MANAGEMENT_CONTROLLER_TWO;
      default:         return itsp_pkg::DEST_NONE;
    endcase
    return (r == itsp_pkg::ROUTE_OFF) ? itsp_pkg::DEST_NONE : {1'b0, r};
  endfunction : dest_of

  // Bearer bit enabled by the mask
  function automatic logic mask_ok(
    input logic [15:0]          m,
    input itsp_pkg::itsp_slot_s s
  );
    if (s.chan == itsp_pkg::CH_B1) return m[{1'b0, s.idx}];
    if (s.chan == itsp_pkg::CH_B2) return m[{1'b1, s.idx}];
    return s.chan != itsp_pkg::CH_NONE;
  endfunction : mask_ok

  itsp_pkg::itsp_ctrl_s   ctrl;
  logic [15:0]            bearer_bit_mask;
  itsp_pkg::itsp_dstate_e dstate;

  // Link pins: three-stage synchronisers with agreement filter
  logic [3:0] pin_in;
  logic [3:0] pin_f;
  logic [3:0] next_pin_f;
  assign pin_in = {line_clock_in, frame_sync_in, line_rx_data, dchan_grant};

  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      logic [2:0] sr;
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          sr <= 3'h0;
        end else begin
          sr <= {sr[1:0], pin_in[i]};
        end
      end
      assign next_pin_f[i] = (sr[2] == sr[1]) ? sr[2] : pin_f[i];
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          pin_f[i] <= 1'b0;
        end else begin
          pin_f[i] <= next_pin_f[i];
        end
      end
    end
  endgenerate

  logic lc_rise;
  logic lc_fall;
  logic sync_f;
  logic rxd_f;
  logic grant_f;
  assign lc_rise = next_pin_f[3] & ~pin_f[3];
  assign lc_fall = ~next_pin_f[3] & pin_f[3];
  assign sync_f  = pin_f[2];
  assign rxd_f   = pin_f[1];
  assign grant_f = pin_f[0];

  // Frame position tracking
  logic       active;
  logic [7:0] pos;
  logic       half;
  logic [7:0] last_pos;
  logic       frame_start;
  logic       sample_now;
  logic       drive_now;
  logic       ci_free;
  logic       grant_ok;
  logic [7:0] frame_cnt;

  assign last_pos = !ctrl.general_circuit_iface ? itsp_pkg::IDL_LAST :
                    ctrl.gci_mux ? itsp_pkg::GCI_MUX_LAST :
                    itsp_pkg::GCI_LAST;
  assign frame_start = ctrl.enable & lc_fall & sync_f;
  // GENERAL_CIRCUIT_IFACE moves one bit per two line clocks
  assign drive_now  = active & lc_rise & (~ctrl.general_circuit_iface | ~half);
  assign sample_now = active & lc_fall & (~ctrl.general_circuit_iface | half);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      active <= 1'b0;
      pos    <= 8'h00;
      half   <= 1'b0;
    end else if (frame_start) begin
      active <= 1'b1;
      pos    <= 8'h00;
      half   <= 1'b0;
    end else if (!ctrl.enable) begin
      active <= 1'b0;
    end else if (active && lc_fall) begin
      if (ctrl.general_circuit_iface && !half) begin
        half <= 1'b1;
      end else begin
        half <= 1'b0;
        if (pos == last_pos) begin
          active <= 1'b0;
        end else begin
          pos <= pos + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      frame_cnt <= 8'h00;
    end else if (frame_start) begin
      frame_cnt <= frame_cnt + 8'h01;
    end
  end

  // Slot under the current position
  itsp_pkg::itsp_slot_s slot;
  logic [2:0]           dest;
  logic                 slot_on;
  assign slot    = slot_of(ctrl.general_circuit_iface, pos);
  assign dest    = dest_of(ctrl, slot.chan);
  assign slot_on = mask_ok(bearer_bit_mask, slot)
                   && dest != itsp_pkg::DEST_NONE;

  // Receive path
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctl_rx_valid <= 5'h00;
      ctl_rx_bit   <= 1'b0;
    end else begin
      ctl_rx_valid <= 5'h00;
      if (sample_now && slot_on) begin
        ctl_rx_valid[dest] <= 1'b1;
        ctl_rx_bit         <= rxd_f;
      end
    end
  end

  // Channel 2 C/I free bit, low means free
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ci_free <= 1'b1;
    end else if (!ctrl.general_circuit_iface || !ctrl.gci_mux) begin
      ci_free <= 1'b1;
    end else if (sample_now && pos[7:5] == itsp_pkg::GCI_FREE_CH
                 && pos[4:0] == itsp_pkg::GCI_FREE_POS) begin
      ci_free <= ~rxd_f;
    end
  end

  // Transmit path
  logic tx_bit;
  logic tx_on;
  assign tx_bit = (dest <= itsp_pkg::DEST_MANAGEMENT_CONTROLLER_TWO) ? ctl_tx_bit[dest] : 1'b1;
  assign tx_on  = slot_on &&
                  (slot.chan != itsp_pkg::CH_D ||
                   dstate == itsp_pkg::DS_SEND);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      line_tx_data      <= 1'b1;
      line_tx_data_oe_n <= 1'b1;
      ctl_tx_take       <= 5'h00;
    end else begin
      ctl_tx_take <= 5'h00;
      if (drive_now) begin
        if (tx_on) begin
          ctl_tx_take[dest] <= 1'b1;
        end
        if (!ctrl.general_circuit_iface) begin
          line_tx_data      <= tx_bit;
          line_tx_data_oe_n <= ~tx_on;
        end else begin
          line_tx_data      <= 1'b0;
          line_tx_data_oe_n <= ~(tx_on & ~tx_bit);
        end
      end else if (!active) begin
        line_tx_data      <= 1'b1;
        line_tx_data_oe_n <= 1'b1;
      end
    end
  end

  // Bearer strobes follow the drive edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bearer_strobe_one <= 1'b0;
      bearer_strobe_two <= 1'b0;
    end else if (drive_now) begin
      bearer_strobe_one <= slot.chan == itsp_pkg::CH_B1
                           && mask_ok(bearer_bit_mask, slot);
      bearer_strobe_two <= slot.chan == itsp_pkg::CH_B2
                           && mask_ok(bearer_bit_mask, slot);
    end else if (!active) begin
      bearer_strobe_one <= 1'b0;
      bearer_strobe_two <= 1'b0;
    end
  end

  // Data-rate clock for non-bus devices
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_rate_clock_out <= 1'b0;
    end else if (!(ctrl.enable && ctrl.general_circuit_iface)) begin
      data_rate_clock_out <= 1'b0;
    end else if (lc_rise) begin
      data_rate_clock_out <= ~data_rate_clock_out;
    end
  end

  // D-channel contention
  logic grant_now;
  assign grant_now = ctrl.general_circuit_iface ? (grant_f & ci_free)
                              : grant_f;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dchan_request <= 1'b0;
    end else begin
      dchan_request <= ctrl.enable & ~ctrl.general_circuit_iface & dchan_pending;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      grant_ok <= 1'b0;
    end else if (frame_start) begin
      grant_ok <= grant_now;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dstate      <= itsp_pkg::DS_IDLE;
      dchan_abort <= 1'b0;
      dchan_fail  <= 1'b0;
    end else begin
      dchan_abort <= 1'b0;
      dchan_fail  <= 1'b0;
      if (frame_start) begin
        unique case (dstate)
          itsp_pkg::DS_IDLE: begin
            if (dchan_pending) begin
              dstate <= grant_now ? itsp_pkg::DS_SEND : itsp_pkg::DS_WAIT;
            end
          end
          itsp_pkg::DS_WAIT: begin
            if (!dchan_pending) begin
              dstate <= itsp_pkg::DS_IDLE;
            end else if (grant_now) begin
              dstate <= itsp_pkg::DS_SEND;
            end
          end
          itsp_pkg::DS_SEND: begin
            if (!dchan_pending) begin
              dstate <= itsp_pkg::DS_IDLE;
            end else if (!grant_now) begin
              dchan_abort <= 1'b1;
              if (dchan_early) begin
                dstate <= itsp_pkg::DS_WAIT;
              end else begin
                dchan_fail <= 1'b1;
                dstate     <= itsp_pkg::DS_IDLE;
              end
            end
          end
          default: dstate <= itsp_pkg::DS_IDLE;
        endcase
      end
    end
  end

  assign dchan_sending = dstate == itsp_pkg::DS_SEND;

  // Register port
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl            <= itsp_pkg::CTRL_RST;
      bearer_bit_mask <= itsp_pkg::MASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == itsp_pkg::ADDR_CTRL) begin
        ctrl <= reg_wdata[itsp_pkg::CTRL_W-1:0];
      end
      if (reg_addr == itsp_pkg::ADDR_MASK) begin
        bearer_bit_mask <= reg_wdata[15:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        itsp_pkg::ADDR_CTRL: reg_rdata <= {23'h0, ctrl};
        itsp_pkg::ADDR_MASK: reg_rdata <= {16'h0, bearer_bit_mask};
        itsp_pkg::ADDR_STAT: reg_rdata <= {18'h0, dstate, grant_ok,
                                           ci_free, active, pin_f[3],
                                           frame_cnt};
        default:             reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : itsp_port

// ===== dv/itsp_port_assertions.sv
// Checker of the serial port outputs
`timescale 1ns/1ps

module itsp_port_chk (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        line_tx_data,
  input wire logic        line_tx_data_oe_n,
  input wire logic        dchan_request,
  input wire logic        bearer_strobe_one,
  input wire logic        bearer_strobe_two,
  input wire logic        data_rate_clock_out,
  input wire logic [4:0]  ctl_tx_take,
  input wire logic [4:0]  ctl_rx_valid,
  input wire logic        dchan_pending,
  input wire logic        dchan_abort,
  input wire logic        dchan_fail
);
  itsp_pkg::itsp_ctrl_s ctl_q;
  logic [15:0]          mask_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // Shadow of control and mask registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctl_q <= itsp_pkg::CTRL_RST;
    end else if (reg_wr && reg_addr == itsp_pkg::ADDR_CTRL) begin
      ctl_q <= reg_wdata[8:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mask_q <= itsp_pkg::MASK_RST;
    end else if (reg_wr && reg_addr == itsp_pkg::ADDR_MASK) begin
      mask_q <= reg_wdata[15:0];
    end
  end

  reset_idle_a: assert property ($fell(srst) |-> line_tx_data
    && line_tx_data_oe_n && !dchan_request && !data_rate_clock_out)
    else $error("Outputs not idle after reset");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("Read data without a read");
  mask_read_a: assert property (reg_rd && reg_addr == 4'h4 |=>
    reg_rdata[15:0] == mask_q) else $error("Mask read mismatch");
  gci_drain_a: assert property (ctl_q.general_circuit_iface && !line_tx_data_oe_n
    |-> !line_tx_data) else $error("Open drain line driven high");
  request_on_a: assert property (ctl_q.enable && !ctl_q.general_circuit_iface
    && dchan_pending |=> dchan_request) else $error("Request missing");
  request_off_a: assert property (!dchan_pending |=> !dchan_request)
    else $error("Request without pending data");
  rate_clk_a: assert property (!ctl_q.general_circuit_iface ##1 !ctl_q.general_circuit_iface
    |-> !data_rate_clock_out) else $error("Rate clock in link mode");
  strobe_excl_a: assert property (!(bearer_strobe_one
    && bearer_strobe_two)) else $error("Both strobes high");
  strobe_mask_a: assert property (mask_q[7:0] == 8'h00 ##1
    mask_q[7:0] == 8'h00 |-> !bearer_strobe_one)
    else $error("Strobe on masked bits");
  off_float_a: assert property (!ctl_q.enable ##1 !ctl_q.enable
    |-> line_tx_data_oe_n && ctl_rx_valid == 5'h00)
    else $error("Port active while disabled");
  one_ctl_a: assert property ($onehot0(ctl_rx_valid)
    && $onehot0(ctl_tx_take)) else $error("Bit routed twice");
  fail_abort_a: assert property (dchan_fail |-> dchan_abort)
    else $error("Fail without abort");
  abort_pulse_a: assert property (dchan_abort |=> !dchan_abort)
    else $error("Abort longer than a cycle");
endmodule : itsp_port_chk

bind itsp_port itsp_port_chk i_itsp_port_chk (
  .ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .line_tx_data, .line_tx_data_oe_n, .dchan_request, .bearer_strobe_one,
  .bearer_strobe_two, .data_rate_clock_out, .ctl_tx_take, .ctl_rx_valid,
  .dchan_pending, .dchan_abort, .dchan_fail
);

// ===== dv/itsp_xcvr.sv
// Transceiver model: masters line clock, sync, receive data and grant
`timescale 1ns/1ps

module itsp_xcvr (
  input  wire logic        go,
  input  wire logic [1:0]  cpb,
  input  wire logic [8:0]  nbits,
  input  wire logic [31:0] rx_pat,
  input  wire logic        grant_in,
  output logic             line_clock_in,
  output logic             frame_sync_in,
  output logic             line_rx_data,
  output logic             dchan_grant,
  output logic             busy
);
  int i;

  assign dchan_grant = grant_in;

  initial begin
    line_clock_in = 1'b0;
    frame_sync_in = 1'b0;
    line_rx_data  = 1'b1;
    busy          = 1'b0;
  end

  // One frame at 200 ns per clock; clock stands still between frames
  always @(posedge go) begin
    busy = 1'b1;
    #5 line_clock_in = 1'b1;
    #50 frame_sync_in = 1'b1;
    #50 line_clock_in = 1'b0;
    #50 frame_sync_in = 1'b0;
    #50;
    for (i = 0; i < nbits * cpb; i++) begin
      line_clock_in = 1'b1;
      if (i % cpb == 0) line_rx_data = rx_pat[(i / cpb) % 32];
      #100 line_clock_in = 1'b0;
      #100;
    end
    // Pull-up level once the frame is over
    line_rx_data = 1'b1;
    busy = 1'b0;
  end
endmodule : itsp_xcvr

// ===== dv/tb_top.sv
// Self-checking bench of the ISDN TDM serial port
`timescale 1ns/1ps

module tb_top;
  logic        ref_clk, srst, reg_wr, reg_rd;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rx_pat;
  logic        line_clock_in, frame_sync_in, line_rx_data, dchan_grant;
  logic        line_tx_data, line_tx_data_oe_n, dchan_request;
  logic        bearer_strobe_one, bearer_strobe_two, data_rate_clock_out;
  logic [4:0]  ctl_tx_bit, ctl_tx_take, ctl_rx_valid;
  logic        ctl_rx_bit, dchan_pending, dchan_early;
  logic        dchan_abort, dchan_fail, dchan_sending;
  logic        go, busy, grant_in, line_wire, drco_q;
  logic [1:0]  cpb;
  logic [8:0]  nbits;
  logic [63:0] wsr, ssr, osr;
  logic [15:0] rx0;
  int          errors, tests_run, cyc, nab, nfl, ntg;
  int          rxc[5], tkc[5];

  // Pull-up on the transmit line
  assign line_wire = line_tx_data_oe_n ? 1'b1 : line_tx_data;

  itsp_port i_itsp_port (
    .ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .line_clock_in, .frame_sync_in, .line_rx_data, .dchan_grant,
    .line_tx_data, .line_tx_data_oe_n, .dchan_request, .bearer_strobe_one,
    .bearer_strobe_two, .data_rate_clock_out, .ctl_tx_bit, .ctl_tx_take,
    .ctl_rx_bit, .ctl_rx_valid, .dchan_pending, .dchan_early, .dchan_abort,
    .dchan_fail, .dchan_sending
  );

  itsp_xcvr i_itsp_xcvr (
    .go, .cpb, .nbits, .rx_pat, .grant_in, .line_clock_in, .frame_sync_in,
    .line_rx_data, .dchan_grant, .busy
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    drco_q <= data_rate_clock_out;
    if (data_rate_clock_out !== drco_q) ntg <= ntg + 1;
    if (dchan_abort === 1'b1) nab <= nab + 1;
    if (dchan_fail === 1'b1) nfl <= nfl + 1;
    if (ctl_rx_valid[0] === 1'b1) rx0 <= {rx0[14:0], ctl_rx_bit};
    for (int k = 0; k < 5; k++) begin
      if (ctl_rx_valid[k] === 1'b1) rxc[k] <= rxc[k] + 1;
      if (ctl_tx_take[k] === 1'b1) tkc[k] <= tkc[k] + 1;
    end
    if (cyc == 20000) begin
      errors = errors + 1;
      conclude();
    end
  end

  // Line level and strobe seen once per line clock
  always @(negedge line_clock_in) begin
    #60;
    wsr = {wsr[62:0], line_wire};
    ssr = {ssr[62:0], bearer_strobe_one};
    osr = {osr[62:0], line_tx_data_oe_n};
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("Checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
    @(posedge ref_clk);
  endtask : reg_read

  task automatic clr();
    nab = 0;
    nfl = 0;
    ntg = 0;
    rx0 = 16'h0;
    for (int k = 0; k < 5; k++) begin
      rxc[k] = 0;
      tkc[k] = 0;
    end
  endtask : clr

  task automatic frame(input logic [1:0] c, input logic [8:0] n);
    cpb   <= c;
    nbits <= n;
    go    <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    while (busy === 1'b1 && cyc < 20000) @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
  endtask : frame

  task automatic t_regs();
    logic [31:0] d;
    reg_read(itsp_pkg::ADDR_CTRL, d);
    chk(d, {23'h0, itsp_pkg::CTRL_RST});
    reg_read(itsp_pkg::ADDR_MASK, d);
    chk(d, {16'h0, itsp_pkg::MASK_RST});
    reg_write(itsp_pkg::ADDR_MASK, 32'h0000_5AA5);
    reg_write(4'hC, 32'hFFFF_FFFF);
    reg_read(4'hC, d);
    chk(d, 32'h0);
    reg_read(itsp_pkg::ADDR_MASK, d);
    chk(d, 32'h0000_5AA5);
  endtask : t_regs

  task automatic t_link();
    logic [15:0] m, er;
    logic [19:0] ew, es, eo;
    logic [31:0] d;
    int          n;
    m = 16'h5AA5;
    er = 16'h0;
    n = 0;
    for (int i = 0; i < 20; i++) begin
      ew[19 - i] = 1'b1;
      es[19 - i] = 1'b0;
      eo[19 - i] = ~(i == 9 || i == 19);
      if (i < 8) begin
        ew[19 - i] = ~m[i];
        es[19 - i] = m[i];
        eo[19 - i] = ~m[i];
        if (m[i]) er = {er[14:0], rx_pat[i]};
        n = n + m[i];
      end else if (i >= 10 && i < 18) begin
        ew[19 - i] = ~m[i - 2];
        eo[19 - i] = ~m[i - 2];
      end
    end
    // B1 to first, B2 to second controller, D off
    reg_write(itsp_pkg::ADDR_CTRL, 32'h0000_014C);
    clr();
    frame(2'h1, 9'h014);
    chk(wsr[19:0], ew);
    chk(ssr[19:0], es);
    chk(rx0, er);
    chk(rxc[0], n);
    chk(tkc[1], $countones(m[15:8]));
    chk(osr[19:0], eo);
    reg_read(itsp_pkg::ADDR_STAT, d);
    chk(d, 32'h0000_0C01);
  endtask : t_link

  task automatic t_gci();
    logic [15:0] m;
    logic [63:0] ew, es;
    m = 16'h0096;
    for (int k = 0; k < 64; k++) begin
      es[63 - k] = (k / 2 < 8) && m[k / 2];
      ew[63 - k] = ~es[63 - k];
    end
    reg_write(itsp_pkg::ADDR_MASK, {16'h0, m});
    // Channel 0 mode, B1 to third controller, rest off
    reg_write(itsp_pkg::ADDR_CTRL, 32'h0000_01ED);
    clr();
    frame(2'h2, 9'h020);
    chk(wsr, ew);
    chk(ssr, es);
    chk(ntg, 65);
    chk(rxc[2], $countones(m[7:0]));
    chk(tkc[2], $countones(m[7:0]));
    reg_write(itsp_pkg::ADDR_CTRL, 32'h0);
  endtask : t_gci

  task automatic t_dch();
    logic [3:0] g, e;
    g = 4'b0101;
    e = 4'b0011;
    reg_write(itsp_pkg::ADDR_MASK, 32'h0);
    // D to first controller, bearers off, link mode
    reg_write(itsp_pkg::ADDR_CTRL, 32'h0000_01F0);
    clr();
    dchan_pending <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(dchan_request, 1'b1);
    for (int k = 0; k < 4; k++) begin
      grant_in    <= g[k];
      dchan_early <= e[k];
      frame(2'h1, 9'h014);
      chk({wsr[11], wsr[1]}, {2{~g[k]}});
    end
    chk(nab, 2);
    chk(nfl, 1);
    chk(tkc[0], 4);
    dchan_pending <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(dchan_request, 1'b0);
  endtask : t_dch

  task automatic t_mux();
    logic [31:0] d;
    rx_pat   <= 32'h2000_0000;
    grant_in <= 1'b1;
    // Multiplexed GENERAL_CIRCUIT_IFACE, all routes off, channel 2 reports busy
    reg_write(itsp_pkg::ADDR_CTRL, 32'h0000_01FF);
    clr();
    frame(2'h2, 9'h100);
    chk(rxc[3], 8);
    chk(rxc[4], 6);
    reg_read(itsp_pkg::ADDR_STAT, d);
    chk(d, 32'h0000_0807);
  endtask : t_mux

  initial begin
    srst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    go = 1'b0;
    grant_in = 1'b1;
    rx_pat = 32'hC3A5_96E1;
    cpb = 2'h1;
    nbits = 9'h014;
    ctl_tx_bit = 5'h18;
    dchan_pending = 1'b0;
    dchan_early = 1'b1;
    errors = 0;
    tests_run = 0;
    cyc = 0;
    wsr = 64'h0;
    ssr = 64'h0;
    osr = 64'h0;
    clr();
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_link();
    t_gci();
    t_dch();
    t_mux();
    conclude();
  end
endmodule : tb_top
